/* hdl/tblp_fifo.sv */
`timescale 1ns/1ps
module tblp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_vld_i,
  output logic                  in_rdy_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_vld_o,
  input  wire logic             out_rdy_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_rdy_o   = (count_r < (AW+1)'(DEPTH));
  assign out_vld_o  = (count_r != '0);
  assign out_data_o = mem_r[rd_ptr_r];
  assign push       = in_vld_i && in_rdy_o;
  assign pop        = out_vld_o && out_rdy_i;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

/* hdl/tblp_pkg.sv */
// Operation
// RULE1 - A PIO word moves only while busy reads zero and data request reads one.
// RULE2 - PIO is 16 bits wide; an optional 8-bit PIO width is also offered.
// RULE3 - PIO data forms blocks of bytes numbered from zero to n-1.
// RULE4 - Device raises DMA request; a DMA word moves only under host acknowledge.
// RULE5 - Every DMA word uses the full 16-bit width; no 8-bit DMA.
// RULE6 - Each acknowledge assertion is one burst of at least two bytes.
// RULE7 - 16-bit words carry even byte low and following odd byte high.
// RULE8 - 8-bit PIO carries one byte per transfer on low lines, ascending.
// RULE9 - ASCII string characters are always printable codes 20h through 7Eh.
// RULE10 - ASCII words carry the earlier character high and the next one low.
// RULE11 - Lane order binds the bus only; host memory order may differ.
package tblp_pkg;
  localparam int          BYTE_W     = 8;
  localparam int          DATA_W     = 16;
  localparam int          FIFO_DEPTH = 32;
  localparam int          IDX_W      = 16;
  localparam logic [7:0]  ASCII_MIN  = 8'h20;
  localparam logic [7:0]  ASCII_MAX  = 8'h7e;
  localparam logic [7:0]  ASCII_FILL = 8'h20;
  localparam logic [7:0]  PAD_BYTE   = 8'h00;
  localparam logic [15:0] DD_RESET   = 16'h0000;
  localparam logic [15:0] CNT_TWO    = 16'h0002;
  typedef enum logic {TBLP_PK_EMPTY, TBLP_PK_HALF} tblp_pk_e;
endpackage

/* hdl/tblp_top.sv */
`timescale 1ns/1ps
module tblp_top (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  byte_i,
  input  wire logic        byte_vld_i,
  input  wire logic        byte_last_i,
  input  wire logic        byte_ascii_i,
  output logic             byte_rdy_o,
  input  wire logic        dma_mode_i,
  input  wire logic        pio8_i,
  input  wire logic        rd_i,
  input  wire logic        dmack_n_i,
  output logic [15:0]      dd_o,
  output logic             dd_oe_n_o,
  output logic             bsy_o,
  output logic             drq_o,
  output logic             dmarq_o
);
  // ------------------------------------------------------------------
  // Byte packing.
  // ------------------------------------------------------------------
  tblp_pkg::tblp_pk_e pk_r;
  logic [7:0]         hold_r;
  logic [15:0]        idx_r;
  logic               narrow;
  logic [7:0]         cur;
  logic               accept;
  logic               push;
  logic [15:0]        push_data;
  logic               fifo_in_rdy;
  logic [15:0]        fifo_data;
  logic               fifo_vld;
  logic               fifo_pop;
  logic [15:0]        dd_r;
  logic               out_vld_r;
  logic               take;
  logic               pio_ok;
  logic               dma_ok;
  logic [15:0]        burst_cnt_r;

  function automatic logic [7:0] tblp_clean(input logic [7:0] b);
    if (b < tblp_pkg::ASCII_MIN || b > tblp_pkg::ASCII_MAX) begin
      return tblp_pkg::ASCII_FILL;
    end
    return b;
  endfunction

  assign narrow     = pio8_i && !dma_mode_i; // RULE2 RULE5
  assign cur        = byte_ascii_i ? tblp_clean(byte_i) : byte_i; // RULE9
  assign byte_rdy_o = fifo_in_rdy;
  assign accept     = byte_vld_i && byte_rdy_o;
  assign push       = accept && (narrow || pk_r == tblp_pkg::TBLP_PK_HALF || byte_last_i);

  always_comb begin
    push_data = {tblp_pkg::PAD_BYTE, cur};
    if (narrow) begin
      push_data = {tblp_pkg::PAD_BYTE, cur}; // RULE8
    end else if (pk_r == tblp_pkg::TBLP_PK_HALF) begin
      push_data = byte_ascii_i ? {hold_r, cur} : {cur, hold_r}; // RULE7 RULE10
    end else if (byte_ascii_i) begin
      push_data = {cur, tblp_pkg::PAD_BYTE}; // RULE10
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pk_r   <= tblp_pkg::TBLP_PK_EMPTY;
      hold_r <= tblp_pkg::PAD_BYTE;
    end else if (accept) begin
      if (!narrow && pk_r == tblp_pkg::TBLP_PK_EMPTY && !byte_last_i) begin
        pk_r   <= tblp_pkg::TBLP_PK_HALF;
        hold_r <= cur;
      end else begin
        pk_r <= tblp_pkg::TBLP_PK_EMPTY;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      idx_r <= '0;
    end else if (accept) begin
      idx_r <= byte_last_i ? '0 : idx_r + 1'b1; // RULE3
    end
  end

  // ------------------------------------------------------------------
  // Word buffer.
  // ------------------------------------------------------------------
  tblp_fifo #(
    .WIDTH (tblp_pkg::DATA_W),
    .DEPTH (tblp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .in_data_i  (push_data),
    .in_vld_i   (push),
    .in_rdy_o   (fifo_in_rdy),
    .out_data_o (fifo_data),
    .out_vld_o  (fifo_vld),
    .out_rdy_i  (fifo_pop)
  );

  // ------------------------------------------------------------------
  // Bus side.
  // ------------------------------------------------------------------
  assign pio_ok    = !dma_mode_i && out_vld_r;
  assign dma_ok    = dma_mode_i && out_vld_r && !dmack_n_i;
  assign bsy_o     = !pio_ok; // RULE1
  assign drq_o     = pio_ok; // RULE1
  assign dmarq_o   = dma_mode_i && out_vld_r; // RULE4
  assign dd_oe_n_o = !(pio_ok || dma_ok);
  assign take      = rd_i && (pio_ok || dma_ok); // RULE1 RULE4
  assign fifo_pop  = fifo_vld && (!out_vld_r || take);
  assign dd_o      = dd_r;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      dd_r      <= tblp_pkg::DD_RESET;
      out_vld_r <= 1'b0;
    end else if (fifo_pop) begin
      dd_r      <= fifo_data;
      out_vld_r <= 1'b1;
    end else if (take) begin
      out_vld_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      burst_cnt_r <= '0;
    end else if (dmack_n_i) begin
      burst_cnt_r <= '0;
    end else if (take && dma_mode_i) begin
      burst_cnt_r <= burst_cnt_r + tblp_pkg::CNT_TWO; // RULE6
    end
  end

  // ------------------------------------------------------------------
  // Assertions.
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_pio_gate_ok: assert property ( // RULE1
    take && !dma_mode_i |-> !bsy_o && drq_o && !dd_oe_n_o)
    else $error("PIO word moved without ready status.");

  a_dma_status: assert property ( // RULE1
    dma_mode_i |-> bsy_o && !drq_o)
    else $error("PIO status offered while in DMA mode.");

  a_take_empty: assert property ( // RULE1
    take && !fifo_vld |=> !out_vld_r && bsy_o)
    else $error("Taken word still shown with nothing left.");

  a_pio8_low_lane: assert property ( // RULE8
    push && narrow |-> push_data[15:8] == tblp_pkg::PAD_BYTE && push_data[7:0] == cur)
    else $error("Narrow PIO byte not on low lanes.");

  a_block_index: assert property ( // RULE3
    accept && !byte_last_i |=> idx_r == $past(idx_r) + 16'h0001)
    else $error("Block byte index did not advance.");

  a_block_restart: assert property ( // RULE3
    accept && byte_last_i |=> idx_r == 16'h0000)
    else $error("Block byte index not restarted.");

  a_dma_ack_gate: assert property ( // RULE4
    take && dma_mode_i |-> dmarq_o && !dmack_n_i)
    else $error("DMA word moved without request and acknowledge.");

  a_pio_no_dmarq: assert property ( // RULE4
    !dma_mode_i |-> !dmarq_o)
    else $error("DMA requested while in PIO mode.");

  a_oe_no_ack: assert property ( // RULE4
    dma_mode_i && dmack_n_i |-> dd_oe_n_o)
    else $error("Data lines driven in DMA without acknowledge.");

  a_dma_full_width: assert property ( // RULE5
    push && dma_mode_i |-> pk_r == tblp_pkg::TBLP_PK_HALF || byte_last_i)
    else $error("DMA word pushed from a single byte.");

  a_burst_min: assert property ( // RULE6
    $rose(dmack_n_i) |-> burst_cnt_r >= tblp_pkg::CNT_TWO)
    else $error("DMA burst shorter than two bytes.");

  a_wide_order: assert property ( // RULE7
    push && !narrow && !byte_ascii_i && pk_r == tblp_pkg::TBLP_PK_HALF
    |-> push_data[7:0] == hold_r)
    else $error("Even byte not on low lanes.");

  a_odd_binary_pad: assert property ( // RULE7
    push && !narrow && !byte_ascii_i && pk_r == tblp_pkg::TBLP_PK_EMPTY
    |-> push_data == {tblp_pkg::PAD_BYTE, cur})
    else $error("Odd last byte not on low lanes.");

  a_ascii_range: assert property ( // RULE9
    push && byte_ascii_i |-> cur >= 8'h20 && cur <= 8'h7e)
    else $error("Non-printable ASCII character sent.");

  a_ascii_order: assert property ( // RULE10
    push && !narrow && byte_ascii_i && pk_r == tblp_pkg::TBLP_PK_HALF
    |-> push_data[15:8] == hold_r)
    else $error("Earlier ASCII character not on high lanes.");

  a_odd_ascii_pad: assert property ( // RULE10
    push && !narrow && byte_ascii_i && pk_r == tblp_pkg::TBLP_PK_EMPTY
    |-> push_data == {cur, tblp_pkg::PAD_BYTE})
    else $error("Odd last character not on high lanes.");

  a_data_held: assert property (
    out_vld_r && !take |=> out_vld_r && $stable(dd_o))
    else $error("Presented word changed before it was taken.");

  a_stage_refill: assert property (
    fifo_vld && !out_vld_r |=> out_vld_r)
    else $error("Buffered word not moved to the output stage.");

  // ------------------------------------------------------------------
  // Coverage.
  // ------------------------------------------------------------------

  c_pio_word: cover property (take && !dma_mode_i);
  c_pio8_word: cover property (push && narrow);
  c_dma_burst: cover property (!dmack_n_i && take ##1 dmack_n_i);
  c_ascii_word: cover property (push && byte_ascii_i && pk_r == tblp_pkg::TBLP_PK_HALF);
  c_odd_last: cover property (push && !narrow && pk_r == tblp_pkg::TBLP_PK_EMPTY);
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic        dma, p8, asc, two;
    logic [7:0]  b0, b1;
    logic [15:0] exp;
  } tblp_row_s;
  logic        mclk_i, rst_i, byte_vld_i, byte_last_i, byte_ascii_i, byte_rdy_o;
  logic        dma_mode_i, pio8_i, rd_i, dmack_n_i, dd_oe_n_o, bsy_o, drq_o, dmarq_o;
  logic        host_en, got_o;
  logic [7:0]  byte_i;
  logic [15:0] dd_o, word_o;
  int          bad_count, cmp_count, n;
  tblp_row_s   rows [9] = '{
    '{1'b0, 1'b0, 1'b0, 1'b1, 8'h11, 8'h22, 16'h2211},
    '{1'b0, 1'b0, 1'b1, 1'b1, 8'h43, 8'h6f, 16'h436f},
    '{1'b0, 1'b0, 1'b1, 1'b1, 8'h1f, 8'h7f, 16'h2020},
    '{1'b0, 1'b0, 1'b1, 1'b1, 8'h20, 8'h7e, 16'h207e},
    '{1'b0, 1'b0, 1'b0, 1'b0, 8'h77, 8'h00, 16'h0077},
    '{1'b0, 1'b0, 1'b1, 1'b0, 8'h41, 8'h00, 16'h4100},
    '{1'b0, 1'b1, 1'b0, 1'b0, 8'h5a, 8'h00, 16'h005a},
    '{1'b1, 1'b0, 1'b0, 1'b1, 8'h33, 8'h44, 16'h4433},
    '{1'b1, 1'b1, 1'b0, 1'b1, 8'h12, 8'h34, 16'h3412}};
  // ------------------------------------------------------------
  // Design and host model
  // ------------------------------------------------------------
  tblp_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .byte_i(byte_i), .byte_vld_i(byte_vld_i),
    .byte_last_i(byte_last_i), .byte_ascii_i(byte_ascii_i), .byte_rdy_o(byte_rdy_o),
    .dma_mode_i(dma_mode_i), .pio8_i(pio8_i), .rd_i(rd_i), .dmack_n_i(dmack_n_i),
    .dd_o(dd_o), .dd_oe_n_o(dd_oe_n_o), .bsy_o(bsy_o), .drq_o(drq_o), .dmarq_o(dmarq_o));
  tblp_host host (.mclk_i(mclk_i), .rst_i(rst_i), .en_i(host_en), .dma_mode_i(dma_mode_i),
    .dd_i(dd_o), .drq_i(drq_o), .dmarq_i(dmarq_o), .rd_o(rd_i), .dmack_n_o(dmack_n_i),
    .got_o(got_o), .word_o(word_o));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task send(input logic [7:0] b, input logic l, input logic a);
    byte_i <= b;
    byte_last_i <= l;
    byte_ascii_i <= a;
    byte_vld_i <= 1'b1;
    do @(posedge mclk_i); while (byte_rdy_o !== 1'b1);
  endtask
  task get_word(input logic [15:0] exp);
    int w;
    w = 0;
    do begin
      @(negedge mclk_i);
      w++;
    end while (got_o !== 1'b1 && w < 200);
    chk({15'h0000, got_o}, 16'h0001);
    chk(word_o, exp);
  endtask
  task summarize;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    bad_count++;
    summarize();
  end
  initial begin
    {rst_i, host_en} = 2'b11;
    {byte_vld_i, byte_last_i, byte_ascii_i, dma_mode_i, pio8_i} = 5'b00000;
    byte_i = 8'h00;
    bad_count = 0;
    cmp_count = 0;
    repeat (7) @(posedge mclk_i);
    @(negedge mclk_i);
    chk({11'h000, bsy_o, drq_o, dmarq_o, dd_oe_n_o, byte_rdy_o}, 16'h0013);
    chk(dd_o, 16'h0000);
    @(posedge mclk_i);
    rst_i <= 1'b0;
    $display("reset test done");
    foreach (rows[i]) begin
      @(posedge mclk_i);
      dma_mode_i <= rows[i].dma;
      pio8_i <= rows[i].p8;
      send(rows[i].b0, !rows[i].two, rows[i].asc);
      if (rows[i].two) send(rows[i].b1, 1'b1, rows[i].asc);
      byte_vld_i <= 1'b0;
      get_word(rows[i].exp);
      $display("row %0d done", i);
    end
    @(posedge mclk_i);
    {host_en, dma_mode_i, pio8_i, byte_ascii_i, byte_last_i} <= 5'b00000;
    byte_vld_i <= 1'b1;
    n = 0;
    repeat (80) begin
      byte_i <= n[7:0];
      @(posedge mclk_i);
      if (byte_rdy_o === 1'b1) n++;
    end
    byte_vld_i <= 1'b0;
    chk(n[15:0], 16'h0042);
    host_en <= 1'b1;
    for (int k = 0; k < 33; k++) get_word({8'(2 * k + 1), 8'(2 * k)});
    $display("fill test done");
    summarize();
  end
endmodule

/* tb/tblp_host.sv */
`timescale 1ns/1ps
module tblp_host (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        en_i,
  input  wire logic        dma_mode_i,
  input  wire logic [15:0] dd_i,
  input  wire logic        drq_i,
  input  wire logic        dmarq_i,
  output logic             rd_o,
  output logic             dmack_n_o,
  output logic             got_o,
  output logic [15:0]      word_o
);
  logic ok;
  assign ok = dma_mode_i ? (dmarq_i && !dmack_n_o) : drq_i;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_o <= 1'b0;
      dmack_n_o <= 1'b1;
      got_o <= 1'b0;
      word_o <= 16'h0000;
    end else begin
      got_o <= rd_o && ok;
      rd_o <= 1'b0;
      if (rd_o && ok) begin
        word_o <= dd_i;
        dmack_n_o <= 1'b1;
      end else if (en_i && ok) begin
        rd_o <= 1'b1;
      end else if (en_i && dma_mode_i && dmarq_i) begin
        dmack_n_o <= 1'b0;
      end
    end
  end
endmodule
